// ==== logic/cpuexe_params.svh ====
// constants for the arithmetic, shift and branch execution datapath
// assumes inclusion by logic/cpuexe_pkg.sv and logic/cpuexe_core.sv
`ifndef CPUEXE_PARAMS_SVH
`define CPUEXE_PARAMS_SVH
`define CPUEXE_WIDTH          16
`define CPUEXE_NREGS          16
`define CPUEXE_SEL_W          4
`define CPUEXE_IMM10_W        10
`define CPUEXE_IMM5_W         5
`define CPUEXE_TGT_W          23
`define CPUEXE_BYTE_LIMIT     10'h0FF
`define CPUEXE_WORD_LIMIT     10'h3FF
`define CPUEXE_SIMM_MIN       (-512)
`define CPUEXE_SIMM_MAX       511
`define CPUEXE_DEFAULT_WORK_REG 4'h0
`define CPUEXE_TAKEN_CYCLES   2
`define CPUEXE_NIB_MSB        3
`define CPUEXE_BYTE_MSB       7
`define CPUEXE_WORD_MSB       15
`endif

// ==== logic/cpuexe_pkg.sv ====
// types for the execution datapath: operations, operand forms, conditions
// assumes cpuexe_params.svh is on the include path
`include "cpuexe_params.svh"
package cpuexe_pkg;
  typedef enum logic [3:0] {
    CPUEXE_OP_NOP,
    CPUEXE_OP_ADD,
    CPUEXE_OP_ADD_WITH_CARRY,
    CPUEXE_OP_SHR1,
    CPUEXE_OP_SHR_MULTI,
    CPUEXE_OP_BIT_RESET,
    CPUEXE_OP_BIT_SET,
    CPUEXE_OP_COND_BRANCH,
    CPUEXE_OP_JUMP,
    CPUEXE_OP_COMPUTED_JUMP
  } cpuexe_op_t;

  typedef enum logic [2:0] {
    CPUEXE_SRC_REG,
    CPUEXE_SRC_FILE,
    CPUEXE_SRC_IMM5,
    CPUEXE_SRC_IMM10,
    CPUEXE_SRC_SIMM10
  } cpuexe_src_t;

  typedef enum logic [3:0] {
    CPUEXE_CC_C, CPUEXE_CC_GE, CPUEXE_CC_UNS_AT_LEAST, CPUEXE_CC_GT, CPUEXE_CC_GTU,
    CPUEXE_CC_LE, CPUEXE_CC_UNS_AT_MOST, CPUEXE_CC_LT, CPUEXE_CC_LTU, CPUEXE_CC_N,
    CPUEXE_CC_NC, CPUEXE_CC_NN, CPUEXE_CC_NWRAP, CPUEXE_CC_NZ, CPUEXE_CC_WRAP,
    CPUEXE_CC_Z
  } cpuexe_cond_t;

  typedef enum logic {
    CPUEXE_ST_EXEC,
    CPUEXE_ST_FLUSH
  } cpuexe_state_t;
endpackage : cpuexe_pkg

// ==== logic/cpuexe_core.sv ====
// execution datapath: add, add with carry, arithmetic shifts, bit ops, branches
// assumes decode presents one instruction per cycle while o_READY is high,
// and that the file register value arrives already read on i_FILE_DATA
`include "cpuexe_params.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - four-bit field picks one of sixteen bits
// - ten-bit immediate capped at 255 in byte mode
// - program target literal must be even
// - hold carry, half carry, negative, wrap, sticky zero
// - file forms use register zero as operand
// - register selects pick one of sixteen
// - signed ten-bit immediate is two's complement
// - add-with-carry adds C, one cycle, all flags
// - single shift keeps sign, leaves half carry alone
// - multi shift writes dest, updates N, Z only
// - branch one cycle untaken, two taken, no flags
// - unsigned conditions from carry and zero flags
// - unconditional and computed jump take two cycles
module cpuexe_core #(
  parameter int WIDTH = `CPUEXE_WIDTH,
  parameter int NREGS = `CPUEXE_NREGS
) (
  input  wire logic                        I_CLK,
  input  wire logic                        I_RESET,
  input  wire logic                        i_VALID,
  input  wire cpuexe_pkg::cpuexe_op_t      i_OP,
  input  wire cpuexe_pkg::cpuexe_src_t     i_SRC_KIND,
  input  wire cpuexe_pkg::cpuexe_cond_t    i_COND,
  input  wire logic                        i_BYTE_MODE,
  input  wire logic                        i_TO_DEFAULT,
  input  wire logic [`CPUEXE_SEL_W-1:0]    i_BASE_WORK_REG,
  input  wire logic [`CPUEXE_SEL_W-1:0]    i_SOURCE_OPERAND,
  input  wire logic [`CPUEXE_SEL_W-1:0]    i_DEST_OPERAND,
  input  wire logic [`CPUEXE_SEL_W-1:0]    i_BIT_POSITION_FIELD,
  input  wire logic [`CPUEXE_IMM5_W-1:0]   i_FIVE_BIT_IMMEDIATE,
  input  wire logic [`CPUEXE_IMM10_W-1:0]  i_TEN_BIT_IMMEDIATE,
  input  wire logic [`CPUEXE_TGT_W-1:0]    i_PROGRAM_TARGET_LITERAL,
  input  wire logic [WIDTH-1:0]            i_FILE_DATA,
  output logic                             o_READY,
  output logic                             o_FILE_WE,
  output logic [WIDTH-1:0]                 o_RESULT,
  output logic                             o_BRANCH,
  output logic [`CPUEXE_TGT_W-1:0]         o_TARGET,
  output logic                             o_BAD_OPERAND,
  output logic                             o_CARRY,
  output logic                             o_HALF_CARRY_FLAG,
  output logic                             o_NEGATIVE,
  output logic                             o_SIGNED_WRAP_FLAG,
  output logic                             o_ZERO,
  output logic [WIDTH-1:0]                 o_REG_VIEW
);
  localparam int SELW = $clog2(NREGS);

  if (WIDTH != `CPUEXE_WIDTH || NREGS != `CPUEXE_NREGS || SELW != `CPUEXE_SEL_W) begin : g_size_check
    $error("cpuexe_core: only a 16-bit word and sixteen registers are supported");
  end

  typedef struct packed {
    logic [NREGS-1:0][WIDTH-1:0] regs;
    cpuexe_pkg::cpuexe_state_t   state;
    logic                        c;
    logic                        hc;
    logic                        n;
    logic                        wrap;
    logic                        z;
    logic                        file_we;
    logic [WIDTH-1:0]            result;
    logic                        branch;
    logic [`CPUEXE_TGT_W-1:0]    target;
    logic                        bad;
  } cpuexe_st_t;

  cpuexe_st_t st;
  cpuexe_st_t next_st;

  // =====================================================
  // helpers
  // =====================================================
  function automatic logic [WIDTH-1:0] bit_mask(input logic [SELW-1:0] pos);
    bit_mask = '0;
    bit_mask[pos] = 1'b1;
  endfunction : bit_mask

  // msb index of the selected operand width
  function automatic int msb_of(input logic byte_mode);
    msb_of = byte_mode ? `CPUEXE_BYTE_MSB : `CPUEXE_WORD_MSB;
  endfunction : msb_of

  function automatic logic is_zero(input logic [WIDTH-1:0] v, input logic byte_mode);
    is_zero = byte_mode ? (v[`CPUEXE_BYTE_MSB:0] == 8'h00) : (v == 16'h0000);
  endfunction : is_zero

  // =====================================================
  // operand selection
  // =====================================================
  logic [WIDTH-1:0] opa;
  logic [WIDTH-1:0] opb;
  logic             imm_bad;
  logic             cond_true;

  always_comb begin
    imm_bad = 1'b0;
    opa     = st.regs[i_BASE_WORK_REG];
    opb     = st.regs[i_SOURCE_OPERAND];
    case (i_SRC_KIND)
      cpuexe_pkg::CPUEXE_SRC_FILE: begin
        opa = i_FILE_DATA;
        opb = st.regs[`CPUEXE_DEFAULT_WORK_REG];
      end
      cpuexe_pkg::CPUEXE_SRC_IMM5: begin
        opb = WIDTH'(i_FIVE_BIT_IMMEDIATE);
      end
      cpuexe_pkg::CPUEXE_SRC_IMM10: begin
        opa = st.regs[i_DEST_OPERAND];
        opb = WIDTH'(i_TEN_BIT_IMMEDIATE);
        imm_bad = i_BYTE_MODE && (i_TEN_BIT_IMMEDIATE > `CPUEXE_BYTE_LIMIT);
      end
      cpuexe_pkg::CPUEXE_SRC_SIMM10: begin
        opa = st.regs[i_DEST_OPERAND];
        opb = WIDTH'($signed(i_TEN_BIT_IMMEDIATE));
      end
      default: ;
    endcase
  end

  // =====================================================
  // branch conditions
  // =====================================================
  always_comb begin
    case (i_COND)
      cpuexe_pkg::CPUEXE_CC_C:   cond_true = st.c;
      cpuexe_pkg::CPUEXE_CC_GE:  cond_true = (st.n == st.wrap);
      cpuexe_pkg::CPUEXE_CC_UNS_AT_LEAST: cond_true = st.c;
      cpuexe_pkg::CPUEXE_CC_GT:  cond_true = !st.z && (st.n == st.wrap);
      cpuexe_pkg::CPUEXE_CC_GTU: cond_true = st.c && !st.z;
      cpuexe_pkg::CPUEXE_CC_LE:  cond_true = st.z || (st.n != st.wrap);
      cpuexe_pkg::CPUEXE_CC_UNS_AT_MOST: cond_true = !st.c || st.z;
      cpuexe_pkg::CPUEXE_CC_LT:  cond_true = (st.n != st.wrap);
      cpuexe_pkg::CPUEXE_CC_LTU: cond_true = !st.c;
      cpuexe_pkg::CPUEXE_CC_N:   cond_true = st.n;
      cpuexe_pkg::CPUEXE_CC_NC:  cond_true = !st.c;
      cpuexe_pkg::CPUEXE_CC_NN:  cond_true = !st.n;
      cpuexe_pkg::CPUEXE_CC_NWRAP: cond_true = !st.wrap;
      cpuexe_pkg::CPUEXE_CC_NZ:  cond_true = !st.z;
      cpuexe_pkg::CPUEXE_CC_WRAP: cond_true = st.wrap;
      default:                   cond_true = st.z;
    endcase
  end

  // =====================================================
  // next state
  // =====================================================
  logic [WIDTH:0]   sum;
  logic [4:0]       nib;
  logic [8:0]       low_byte;
  logic [WIDTH-1:0] res;
  logic             cin;
  logic             rmsb;
  logic [SELW-1:0]  wdest;
  int               m;

  always_comb begin
    next_st         = st;
    next_st.file_we = 1'b0;
    next_st.branch  = 1'b0;
    next_st.state   = cpuexe_pkg::CPUEXE_ST_EXEC;
    cin      = (i_OP == cpuexe_pkg::CPUEXE_OP_ADD_WITH_CARRY) ? st.c : 1'b0;
    sum      = {1'b0, opa} + {1'b0, opb} + {{WIDTH{1'b0}}, cin};
    nib      = {1'b0, opa[`CPUEXE_NIB_MSB:0]} + {1'b0, opb[`CPUEXE_NIB_MSB:0]} + {4'h0, cin};
    low_byte = {1'b0, opa[`CPUEXE_BYTE_MSB:0]} + {1'b0, opb[`CPUEXE_BYTE_MSB:0]} + {8'h00, cin};
    m        = msb_of(i_BYTE_MODE);
    res      = '0;
    rmsb     = 1'b0;
    wdest    = i_TO_DEFAULT ? `CPUEXE_DEFAULT_WORK_REG : i_DEST_OPERAND;
    // second cycle of a taken branch is a dead slot: nothing executes
    if (st.state == cpuexe_pkg::CPUEXE_ST_EXEC && i_VALID) begin
      next_st.bad = imm_bad || (i_PROGRAM_TARGET_LITERAL[0] &&
                    (i_OP == cpuexe_pkg::CPUEXE_OP_JUMP || i_OP == cpuexe_pkg::CPUEXE_OP_COND_BRANCH));
      case (i_OP)
        cpuexe_pkg::CPUEXE_OP_ADD, cpuexe_pkg::CPUEXE_OP_ADD_WITH_CARRY: begin
          res  = sum[WIDTH-1:0];
          rmsb = res[m];
          next_st.c  = i_BYTE_MODE ? low_byte[8] : sum[WIDTH];
          next_st.hc = nib[4];
          next_st.n  = rmsb;
          next_st.wrap = (opa[m] == opb[m]) && (rmsb != opa[m]);
          // sticky zero only clears for the carry-chain form
          if (i_OP == cpuexe_pkg::CPUEXE_OP_ADD_WITH_CARRY) begin
            next_st.z = st.z && is_zero(res, i_BYTE_MODE);
          end else begin
            next_st.z = is_zero(res, i_BYTE_MODE);
          end
        end
        cpuexe_pkg::CPUEXE_OP_SHR1: begin
          res  = {opa[WIDTH-1], opa[WIDTH-1:1]};
          if (i_BYTE_MODE) begin
            res[`CPUEXE_BYTE_MSB] = opa[`CPUEXE_BYTE_MSB];
          end
          next_st.c  = opa[0];
          next_st.n  = res[m];
          next_st.wrap = 1'b0;
          next_st.z  = is_zero(res, i_BYTE_MODE);
        end
        cpuexe_pkg::CPUEXE_OP_SHR_MULTI: begin
          res = WIDTH'($signed(opa) >>> ((i_SRC_KIND == cpuexe_pkg::CPUEXE_SRC_IMM5) ?
                  opb[SELW-1:0] : st.regs[i_SOURCE_OPERAND][SELW-1:0]));
          next_st.n = res[WIDTH-1];
          next_st.z = is_zero(res, 1'b0);
        end
        cpuexe_pkg::CPUEXE_OP_BIT_RESET: res = opa & ~bit_mask(i_BIT_POSITION_FIELD);
        cpuexe_pkg::CPUEXE_OP_BIT_SET:   res = opa | bit_mask(i_BIT_POSITION_FIELD);
        cpuexe_pkg::CPUEXE_OP_COND_BRANCH: begin
          if (cond_true) begin
            next_st.branch = 1'b1;
            next_st.target = i_PROGRAM_TARGET_LITERAL;
            next_st.state  = cpuexe_pkg::CPUEXE_ST_FLUSH;
          end
        end
        cpuexe_pkg::CPUEXE_OP_JUMP, cpuexe_pkg::CPUEXE_OP_COMPUTED_JUMP: begin
          next_st.branch = 1'b1;
          next_st.target = (i_OP == cpuexe_pkg::CPUEXE_OP_JUMP) ? i_PROGRAM_TARGET_LITERAL :
                           {7'h00, st.regs[i_SOURCE_OPERAND]};
          next_st.state  = cpuexe_pkg::CPUEXE_ST_FLUSH;
        end
        default: ;
      endcase
      if (i_OP inside {cpuexe_pkg::CPUEXE_OP_ADD, cpuexe_pkg::CPUEXE_OP_ADD_WITH_CARRY,
                       cpuexe_pkg::CPUEXE_OP_SHR1, cpuexe_pkg::CPUEXE_OP_SHR_MULTI,
                       cpuexe_pkg::CPUEXE_OP_BIT_RESET, cpuexe_pkg::CPUEXE_OP_BIT_SET}) begin
        next_st.result = res;
        // byte mode leaves the upper half of a destination register untouched; a file write gets the whole result
        if (i_SRC_KIND == cpuexe_pkg::CPUEXE_SRC_FILE && !i_TO_DEFAULT) begin
          next_st.file_we = 1'b1;
        end else if (i_BYTE_MODE) begin
          next_st.regs[wdest][`CPUEXE_BYTE_MSB:0] = res[`CPUEXE_BYTE_MSB:0];
        end else begin
          next_st.regs[wdest] = res;
        end
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_READY            = (st.state == cpuexe_pkg::CPUEXE_ST_EXEC);
  assign o_FILE_WE          = st.file_we;
  assign o_RESULT           = st.result;
  assign o_BRANCH           = st.branch;
  assign o_TARGET           = st.target;
  assign o_BAD_OPERAND      = st.bad;
  assign o_CARRY            = st.c;
  assign o_HALF_CARRY_FLAG  = st.hc;
  assign o_NEGATIVE         = st.n;
  assign o_SIGNED_WRAP_FLAG = st.wrap;
  assign o_ZERO             = st.z;
  assign o_REG_VIEW         = st.regs[i_DEST_OPERAND];

  // =====================================================
  // checks
  // =====================================================
  property p_taken_two;
    @(posedge I_CLK) disable iff (I_RESET)
    o_BRANCH |-> !o_READY ##1 o_READY;
  endproperty
  a_taken_two: assert property (p_taken_two) else $error("taken branch not two cycles");

  property p_jump_always;
    @(posedge I_CLK) disable iff (I_RESET)
    (o_READY && i_VALID && i_OP == cpuexe_pkg::CPUEXE_OP_JUMP) |=> o_BRANCH && !o_READY;
  endproperty
  a_jump_always: assert property (p_jump_always) else $error("jump did not take");

  property p_branch_flags;
    @(posedge I_CLK) disable iff (I_RESET)
    (o_READY && i_VALID && i_OP == cpuexe_pkg::CPUEXE_OP_COND_BRANCH) |=>
      ({o_CARRY, o_HALF_CARRY_FLAG, o_NEGATIVE, o_SIGNED_WRAP_FLAG, o_ZERO} ==
       $past({o_CARRY, o_HALF_CARRY_FLAG, o_NEGATIVE, o_SIGNED_WRAP_FLAG, o_ZERO}));
  endproperty
  a_branch_flags: assert property (p_branch_flags) else $error("branch changed flags");

  property p_untaken;
    @(posedge I_CLK) disable iff (I_RESET)
    (o_READY && i_VALID && i_OP == cpuexe_pkg::CPUEXE_OP_COND_BRANCH && !cond_true) |=> o_READY && !o_BRANCH;
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken branch stalled");

  property p_unsigned_at_least;
    @(posedge I_CLK) disable iff (I_RESET)
    (o_READY && i_VALID && i_OP == cpuexe_pkg::CPUEXE_OP_COND_BRANCH &&
     i_COND == cpuexe_pkg::CPUEXE_CC_UNS_AT_LEAST) |=> (o_BRANCH == $past(o_CARRY));
  endproperty
  a_unsigned_at_least: assert property (p_unsigned_at_least) else $error("unsigned at-least wrong");

  property p_shr1_keep;
    @(posedge I_CLK) disable iff (I_RESET)
    (o_READY && i_VALID && i_OP == cpuexe_pkg::CPUEXE_OP_SHR1) |=>
      o_HALF_CARRY_FLAG == $past(o_HALF_CARRY_FLAG) && o_RESULT[15] == $past(opa[15]);
  endproperty
  a_shr1_keep: assert property (p_shr1_keep) else $error("single shift broke half carry or sign");

  property p_multi_flags;
    @(posedge I_CLK) disable iff (I_RESET)
    (o_READY && i_VALID && i_OP == cpuexe_pkg::CPUEXE_OP_SHR_MULTI) |=>
      o_CARRY == $past(o_CARRY) && o_NEGATIVE == o_RESULT[15] && o_ZERO == (o_RESULT == 16'h0000);
  endproperty
  a_multi_flags: assert property (p_multi_flags) else $error("multi shift flags wrong");

  property p_sticky_z;
    @(posedge I_CLK) disable iff (I_RESET)
    (o_READY && i_VALID && i_OP == cpuexe_pkg::CPUEXE_OP_ADD_WITH_CARRY && !o_ZERO) |=> !o_ZERO;
  endproperty
  a_sticky_z: assert property (p_sticky_z) else $error("sticky zero set by add with carry");

  property p_imm_range;
    @(posedge I_CLK) disable iff (I_RESET)
    (o_READY && i_VALID && i_SRC_KIND == cpuexe_pkg::CPUEXE_SRC_IMM10 && i_BYTE_MODE &&
     i_TEN_BIT_IMMEDIATE > `CPUEXE_BYTE_LIMIT && i_OP == cpuexe_pkg::CPUEXE_OP_ADD) |=> o_BAD_OPERAND;
  endproperty
  a_imm_range: assert property (p_imm_range) else $error("byte immediate over range not flagged");

  c_taken: cover property (@(posedge I_CLK) disable iff (I_RESET) o_BRANCH);
  c_carry: cover property (@(posedge I_CLK) disable iff (I_RESET) $rose(o_CARRY));
  c_filewr: cover property (@(posedge I_CLK) disable iff (I_RESET) o_FILE_WE);
endmodule : cpuexe_core

`default_nettype wire

// ==== verif/cpuexe_fetch_model.sv ====
// front end model: fetch and decode stage presenting one instruction at a time
// assumes calls at the falling clock edge and the core's ready level on i_READY
`timescale 1ns/1ps
`default_nettype none
module cpuexe_fetch_model (
  input  wire logic                I_CLK,
  input  wire logic                i_READY,
  output logic                     o_VALID,
  output cpuexe_pkg::cpuexe_op_t   o_OP,
  output cpuexe_pkg::cpuexe_src_t  o_SRC_KIND,
  output cpuexe_pkg::cpuexe_cond_t o_COND,
  output logic                     o_BYTE_MODE,
  output logic                     o_TO_DEFAULT,
  output logic [3:0]               o_BASE,
  output logic [3:0]               o_SRC,
  output logic [3:0]               o_DST,
  output logic [3:0]               o_BIT,
  output logic [4:0]               o_IMM5,
  output logic [9:0]               o_IMM10,
  output logic [22:0]              o_TGT,
  output logic [15:0]              o_FILE
);
  // ==========================================================
  // idle state at time zero
  initial begin
    o_VALID = 1'b0;
    o_OP = cpuexe_pkg::CPUEXE_OP_NOP;
    o_SRC_KIND = cpuexe_pkg::CPUEXE_SRC_REG;
    o_COND = cpuexe_pkg::CPUEXE_CC_C;
    {o_BYTE_MODE, o_TO_DEFAULT, o_BASE, o_SRC, o_DST, o_BIT} = '0;
    {o_IMM5, o_IMM10, o_TGT, o_FILE} = '0;
  end

  // ==========================================================
  // one instruction, held until the edge that takes it
  task automatic issue(input cpuexe_pkg::cpuexe_op_t op, input cpuexe_pkg::cpuexe_src_t sk,
                       input logic [3:0] d, b, s, input logic [9:0] k, input logic [22:0] t,
                       input logic [2:0] m, input logic [15:0] f, input cpuexe_pkg::cpuexe_cond_t cc);
    // a flush slot ignores the request, so wait it out first
    while (i_READY !== 1'b1) @(negedge I_CLK);
    o_OP = op;
    o_SRC_KIND = sk;
    o_COND = cc;
    {o_DST, o_BASE, o_SRC} = {d, b, s};
    {o_IMM10, o_IMM5, o_BIT} = {k, k[4:0], k[3:0]};
    // even targets only, unless a test asks for an odd one on purpose
    o_TGT = m[2] ? t : {t[22:1], 1'b0};
    {o_TO_DEFAULT, o_BYTE_MODE} = m[1:0];
    o_FILE = f;
    o_VALID = 1'b1;
    @(posedge I_CLK);
    @(negedge I_CLK);
  endtask : issue

  task automatic show(input logic [3:0] r);
    o_VALID = 1'b0;
    // released fields flip so a stale value cannot pass for a fresh one
    {o_BASE, o_SRC, o_IMM10, o_FILE} = ~{o_BASE, o_SRC, o_IMM10, o_FILE};
    o_DST = r;
    #1;
  endtask : show
endmodule : cpuexe_fetch_model
`default_nettype wire

// ==== verif/cpuexe_core_test.sv ====
// self-checking bench for the execution datapath
// assumes the front end model drives every instruction input of the core
`timescale 1ns/1ps
`default_nettype none
module cpuexe_core_test;
  localparam cpuexe_pkg::cpuexe_op_t op_add = cpuexe_pkg::CPUEXE_OP_ADD, op_adc = cpuexe_pkg::CPUEXE_OP_ADD_WITH_CARRY;
  localparam cpuexe_pkg::cpuexe_op_t op_sh1 = cpuexe_pkg::CPUEXE_OP_SHR1, op_shm = cpuexe_pkg::CPUEXE_OP_SHR_MULTI;
  localparam cpuexe_pkg::cpuexe_op_t op_clr = cpuexe_pkg::CPUEXE_OP_BIT_RESET, op_set = cpuexe_pkg::CPUEXE_OP_BIT_SET;
  localparam cpuexe_pkg::cpuexe_op_t op_br = cpuexe_pkg::CPUEXE_OP_COND_BRANCH, op_jmp = cpuexe_pkg::CPUEXE_OP_JUMP;
  localparam cpuexe_pkg::cpuexe_op_t op_cj = cpuexe_pkg::CPUEXE_OP_COMPUTED_JUMP;
  localparam cpuexe_pkg::cpuexe_src_t s_reg = cpuexe_pkg::CPUEXE_SRC_REG, s_file = cpuexe_pkg::CPUEXE_SRC_FILE;
  localparam cpuexe_pkg::cpuexe_src_t s_i5 = cpuexe_pkg::CPUEXE_SRC_IMM5, s_i10 = cpuexe_pkg::CPUEXE_SRC_IMM10;
  localparam cpuexe_pkg::cpuexe_src_t s_s10 = cpuexe_pkg::CPUEXE_SRC_SIMM10;
  // taken or not per condition code with carry, half carry and zero set, negative and wrap clear
  localparam logic [15:0] taken = 16'h9867;

  logic                     I_CLK, I_RESET, valid, bm, td, ready, fwe, branch, bad, c, hcf, n, swf, z;
  cpuexe_pkg::cpuexe_op_t   op;
  cpuexe_pkg::cpuexe_src_t  sk;
  cpuexe_pkg::cpuexe_cond_t cond;
  logic [3:0]               base, srcr, dst, bitp;
  logic [4:0]               imm5;
  logic [9:0]               imm10;
  logic [22:0]              tgt, target;
  logic [15:0]              fdata, result, rv;
  int                       fails = 0, comparisons = 0, cyc = 0;
  wire logic [4:0]          flg = {c, hcf, n, swf, z};

  cpuexe_fetch_model cpuexe_fetch_model_inst (.I_CLK(I_CLK), .i_READY(ready), .o_VALID(valid), .o_OP(op),
    .o_SRC_KIND(sk), .o_COND(cond), .o_BYTE_MODE(bm), .o_TO_DEFAULT(td), .o_BASE(base), .o_SRC(srcr),
    .o_DST(dst), .o_BIT(bitp), .o_IMM5(imm5), .o_IMM10(imm10), .o_TGT(tgt), .o_FILE(fdata));
  cpuexe_core cpuexe_core_inst (.I_CLK(I_CLK), .I_RESET(I_RESET), .i_VALID(valid), .i_OP(op), .i_SRC_KIND(sk),
    .i_COND(cond), .i_BYTE_MODE(bm), .i_TO_DEFAULT(td), .i_BASE_WORK_REG(base), .i_SOURCE_OPERAND(srcr),
    .i_DEST_OPERAND(dst), .i_BIT_POSITION_FIELD(bitp), .i_FIVE_BIT_IMMEDIATE(imm5), .i_TEN_BIT_IMMEDIATE(imm10),
    .i_PROGRAM_TARGET_LITERAL(tgt), .i_FILE_DATA(fdata), .o_READY(ready), .o_FILE_WE(fwe), .o_RESULT(result),
    .o_BRANCH(branch), .o_TARGET(target), .o_BAD_OPERAND(bad), .o_CARRY(c), .o_HALF_CARRY_FLAG(hcf),
    .o_NEGATIVE(n), .o_SIGNED_WRAP_FLAG(swf), .o_ZERO(z), .o_REG_VIEW(rv));

  // ==========================================================
  // compare and access tasks
  task automatic note(input bit ok, input logic [22:0] g, e);
    comparisons++;
    if (!ok) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : note
  task automatic chk_bit(input logic g, e);
    note(g === e, {22'h0, g}, {22'h0, e});
  endtask : chk_bit
  task automatic chk_flg(input logic [4:0] e);
    note(flg === e, {18'h0, flg}, {18'h0, e});
  endtask : chk_flg
  task automatic chk_val(input logic [22:0] g, e);
    note(g === e, g, e);
  endtask : chk_val
  task automatic reg_is(input logic [3:0] r, input logic [15:0] e);
    cpuexe_fetch_model_inst.show(r);
    chk_val({7'h00, rv}, {7'h00, e});
    @(negedge I_CLK);
  endtask : reg_is
  task automatic ex(input cpuexe_pkg::cpuexe_op_t o, input cpuexe_pkg::cpuexe_src_t s, input logic [3:0] d, b, r,
                    input logic [9:0] k, input logic [22:0] t = 23'h0, input logic [2:0] m = 3'h0,
                    input logic [15:0] f = 16'h0, input logic [3:0] cc = 4'h0);
    cpuexe_fetch_model_inst.issue(o, s, d, b, r, k, t, m, f, cpuexe_pkg::cpuexe_cond_t'(cc));
  endtask : ex
  // a taken transfer must leave exactly one dead slot behind it
  task automatic br_chk(input logic tk, input logic [22:0] t);
    chk_bit(branch, tk);
    chk_bit(ready, !tk);
    if (tk) begin
      chk_val(target, t);
      @(negedge I_CLK);
      chk_bit(ready, 1'b1);
      chk_bit(branch, 1'b0);
    end
  endtask : br_chk
  task automatic results;
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  // ==========================================================
  // clock, timeout and test sequence
  initial begin
    I_CLK = 1'b0;
    forever #12.5 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      results();
    end
  end
  initial begin
    I_RESET = 1'b1;
    repeat (8) @(negedge I_CLK);
    I_RESET = 1'b0;
    chk_flg(5'h00);
    chk_bit(ready, 1'b1);
    ex(op_add, s_i10, 4'h1, 4'h0, 4'h0, 10'h3FF);
    chk_bit(bad, 1'b0);
    ex(op_add, s_i10, 4'h9, 4'h0, 4'h0, 10'h100, 23'h0, 3'h1);
    chk_bit(bad, 1'b1);
    chk_flg(5'h01);
    ex(op_add, s_s10, 4'h2, 4'h0, 4'h0, 10'h200);
    chk_bit(bad, 1'b0);
    chk_flg(5'h04);
    ex(op_add, s_s10, 4'h3, 4'h0, 4'h0, 10'h3FF);
    ex(op_add, s_i10, 4'h4, 4'h0, 4'h0, 10'h001);
    ex(op_add, s_reg, 4'h5, 4'h3, 4'h4, 10'h0);
    chk_flg(5'h19);
    reg_is(4'h1, 16'h03FF);
    reg_is(4'h2, 16'hFE00);
    reg_is(4'h3, 16'hFFFF);
    for (int i = 0; i < 16; i++) begin
      ex(op_br, s_reg, 4'h0, 4'h0, 4'h0, 10'h0, 23'(2 * i + 2), 3'h0, 16'h0, 4'(i));
      br_chk(taken[i], 23'(2 * i + 2));
      chk_flg(5'h19);
    end
    ex(op_adc, s_reg, 4'h6, 4'h4, 4'h4, 10'h0);
    chk_flg(5'h00);
    ex(op_adc, s_reg, 4'h7, 4'h0, 4'h0, 10'h0);
    chk_flg(5'h00);
    reg_is(4'h6, 16'h0003);
    ex(op_add, s_reg, 4'h8, 4'h3, 4'h4, 10'h0);
    ex(op_shm, s_i5, 4'hA, 4'h2, 4'h0, 10'h004);
    chk_flg(5'h1C);
    ex(op_sh1, s_reg, 4'h8, 4'h2, 4'h2, 10'h0);
    chk_flg(5'h0C);
    reg_is(4'hA, 16'hFFE0);
    reg_is(4'h8, 16'hFF00);
    ex(op_set, s_reg, 4'hB, 4'hB, 4'hB, 10'h00F);
    ex(op_clr, s_reg, 4'h2, 4'h2, 4'h2, 10'h00F);
    chk_flg(5'h0C);
    reg_is(4'hB, 16'h8000);
    reg_is(4'h2, 16'h7E00);
    // two positive operands giving a negative sum must raise the wrap flag
    ex(op_add, s_reg, 4'hC, 4'h2, 4'h2, 10'h0);
    chk_flg(5'h06);
    ex(op_add, s_i10, 4'h0, 4'h0, 4'h0, 10'h005);
    ex(op_add, s_file, 4'h0, 4'h0, 4'h0, 10'h0, 23'h0, 3'h0, 16'h0010);
    chk_bit(fwe, 1'b1);
    chk_val({7'h00, result}, 23'h000015);
    ex(op_add, s_file, 4'h0, 4'h0, 4'h0, 10'h0, 23'h0, 3'h2, 16'h0010);
    chk_bit(fwe, 1'b0);
    reg_is(4'h0, 16'h0015);
    ex(op_jmp, s_reg, 4'h0, 4'h0, 4'h0, 10'h0, 23'h012346);
    br_chk(1'b1, 23'h012346);
    ex(op_cj, s_reg, 4'h2, 4'h2, 4'h2, 10'h0);
    br_chk(1'b1, 23'h007E00);
    ex(op_jmp, s_reg, 4'h0, 4'h0, 4'h0, 10'h0, 23'h000101, 3'h4);
    chk_bit(bad, 1'b1);
    br_chk(1'b1, 23'h000101);
    chk_flg(5'h00);
    results();
  end
endmodule : cpuexe_core_test
`default_nettype wire
